//--- host_load_control_port.sv
// host_load_control_port.sv: host-side i/o registers and memory window decode
// of a plug-in network card. assumes host strobes are registered on I_REF_CLK,
// the firmware start pin comes from another domain.
// Notes on behaviour
// - boot handshake byte reads 0x41 once boot completes
// - zero control write disables card entirely
// - base match holds address bits 19:12
// - window span selects size, default 0x3f
// - control 0x40 enables shared memory
// - control 0x20 enables host interrupt
// - line select maps eight codes, else off
// - control 0x80 releases on-card processor
// - card sets control bit 2 when started while control 0x80 is set
`timescale 1ns/1ns
`include "hlcp_consts.svh"
module host_load_control_port (
    input wire logic I_REF_CLK, // 250 mhz clock
    input wire logic I_SRST, // synchronous reset, high
    input wire hlcp_pkg::hlcp_io_req_t I_IO_REQ, // host i/o cycle, same domain
    output logic [7:0] O_IO_RDATA, // register read data
    input wire logic [19:12] I_MEM_ADDR_HI, // host memory address upper byte
    output logic O_MEM_SELECT, // card claims this memory cycle
    input wire logic I_FW_STARTED, // on-card firmware started, async
    input wire logic I_CARD_IRQ, // on-card interrupt request
    output logic O_CPU_RUN, // on-card processor released
    output logic [15:0] O_HOST_IRQ, // host interrupt lines
    output logic O_HOST_IRQ_OE // high while driving an interrupt line
);
    hlcp_pkg::hlcp_ctl_t ctl_r, ctl_nxt;
    logic flag_r, flag_nxt;
    logic [7:0] base_r, base_nxt;
    logic [7:0] span_r, span_nxt;
    logic [3:0] irq_sel_r, irq_sel_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    hlcp_pkg::hlcp_boot_t boot_r, boot_nxt;
    logic [17:0] boot_cnt_r, boot_cnt_nxt;
    logic started_s;
    logic started_d_r;
    logic irq_ok;
    logic [3:0] irq_line;
    logic [7:0] ctl_byte;
    logic wr_ctl, wr_base, wr_span, wr_irq_sel;

    hlcp_sync2 u_fw_sync (
        .i_clk(I_REF_CLK),
        .i_d(I_FW_STARTED),
        .o_q(started_s)
    );

    // control byte as seen by the host
    always_comb begin
        ctl_byte = ctl_r;
        ctl_byte[`HLCP_CTL_FLAG_BIT] = flag_r;
    end

    // boot code sequencing after reset
    always_comb begin
        boot_nxt = boot_r;
        boot_cnt_nxt = boot_cnt_r;
        unique case (boot_r)
            hlcp_pkg::HLCP_IN_RESET: begin
                boot_nxt = hlcp_pkg::HLCP_BOOTING;
                boot_cnt_nxt = 18'h0;
            end
            hlcp_pkg::HLCP_BOOTING: begin
                boot_cnt_nxt = boot_cnt_r + 18'h1;
                if (boot_cnt_r == 18'(`HLCP_BOOT_CYC - 1)) begin
                    boot_nxt = hlcp_pkg::HLCP_READY;
                end
            end
            hlcp_pkg::HLCP_READY: begin
                boot_nxt = hlcp_pkg::HLCP_READY;
            end
        endcase
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_SRST) begin
            boot_r <= hlcp_pkg::HLCP_IN_RESET;
            boot_cnt_r <= 18'h0;
        end else begin
            boot_r <= boot_nxt;
            boot_cnt_r <= boot_cnt_nxt;
        end
    end

    // write strobes decoded from the host i/o cycle
    always_comb begin
        wr_ctl = 1'b0;
        wr_base = 1'b0;
        wr_span = 1'b0;
        wr_irq_sel = 1'b0;
        if (I_IO_REQ.wr) begin
            unique case (I_IO_REQ.addr)
                `HLCP_OFS_CONTROL: wr_ctl = 1'b1;
                `HLCP_OFS_BASE_MATCH: wr_base = 1'b1;
                `HLCP_OFS_SPAN: wr_span = 1'b1;
                `HLCP_OFS_IRQ_SEL: wr_irq_sel = 1'b1;
                default: ; // unmapped offsets ignore writes
            endcase
        end
    end

    // control register: a zero write drops every enable at once
    always_comb begin
        ctl_nxt = ctl_r;
        if (wr_ctl) begin
            ctl_nxt = I_IO_REQ.wdata;
            ctl_nxt.spare_lo = 2'h0; // low bits always read zero
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_SRST) begin
            ctl_r <= '0;
        end else begin
            ctl_r <= ctl_nxt;
        end
    end

    // window placement and size
    always_comb begin
        base_nxt = base_r;
        span_nxt = span_r;
        if (wr_base) begin
            base_nxt = I_IO_REQ.wdata;
        end
        if (wr_span) begin
            span_nxt = I_IO_REQ.wdata;
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_SRST) begin
            base_r <= 8'h00;
            span_r <= `HLCP_SPAN_RST;
        end else begin
            base_r <= base_nxt;
            span_r <= span_nxt;
        end
    end

    // interrupt line select code
    always_comb begin
        irq_sel_nxt = irq_sel_r;
        if (wr_irq_sel) begin
            irq_sel_nxt = I_IO_REQ.wdata[3:0];
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_SRST) begin
            irq_sel_r <= 4'h0;
        end else begin
            irq_sel_r <= irq_sel_nxt;
        end
    end

    // start flag: host write with bit 2 low clears, firmware start sets while run is set
    always_comb begin
        flag_nxt = flag_r;
        if (wr_ctl && !I_IO_REQ.wdata[`HLCP_CTL_FLAG_BIT]) begin
            flag_nxt = 1'b0; // host clears flag by writing zero
        end
        // set wins over a clear in the same cycle if that write keeps run set
        if (started_s && !started_d_r && ctl_nxt.run) begin
            flag_nxt = 1'b1;
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_SRST) begin
            flag_r <= 1'b0;
            started_d_r <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
            started_d_r <= started_s;
        end
    end

    // read data: registered, holds until the next read
    always_comb begin
        rdata_nxt = rdata_r;
        if (I_IO_REQ.rd) begin
            unique case (I_IO_REQ.addr)
                `HLCP_OFS_HANDSHAKE: rdata_nxt = (boot_r == hlcp_pkg::HLCP_READY) ?
                    `HLCP_BOOT_CODE : `HLCP_BOOT_IDLE;
                `HLCP_OFS_CONTROL: rdata_nxt = ctl_byte;
                `HLCP_OFS_BASE_MATCH: rdata_nxt = base_r;
                `HLCP_OFS_SPAN: rdata_nxt = span_r;
                `HLCP_OFS_IRQ_SEL: rdata_nxt = {4'h0, irq_sel_r};
                default: rdata_nxt = 8'h00; // unmapped offsets read zero
            endcase
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_SRST) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // interrupt line decode: eight supported codes, any other disables
    always_comb begin
        irq_ok = 1'b1;
        irq_line = 4'h0;
        unique case (irq_sel_r)
            4'h2: irq_line = 4'h2;
            4'h5: irq_line = 4'h5;
            4'h7: irq_line = 4'h7;
            4'h9: irq_line = 4'h9;
            4'ha: irq_line = 4'ha;
            4'hb: irq_line = 4'hb;
            4'hc: irq_line = 4'hc;
            4'hf: irq_line = 4'hf;
            default: irq_ok = 1'b0;
        endcase
    end

    // outputs
    assign O_IO_RDATA = rdata_r;
    assign O_CPU_RUN = ctl_r.run;
    assign O_MEM_SELECT = ctl_r.mem_en && ((I_MEM_ADDR_HI & ~span_r) == (base_r & ~span_r));
    assign O_HOST_IRQ_OE = ctl_r.irq_en && irq_ok;
    assign O_HOST_IRQ = (O_HOST_IRQ_OE && I_CARD_IRQ) ? (16'h1 << irq_line) : 16'h0;
endmodule : host_load_control_port

//--- hlcp_consts.svh
// hlcp_consts.svh: offsets, field positions, reset values and timing counts
// of the host load control port. included by bare name; definitions only.
`ifndef HLCP_CONSTS_SVH
`define HLCP_CONSTS_SVH

// i/o register offsets within the 8-byte region
`define HLCP_OFS_HANDSHAKE 3'h0
`define HLCP_OFS_CONTROL 3'h1
`define HLCP_OFS_BASE_MATCH 3'h2
`define HLCP_OFS_SPAN 3'h3
`define HLCP_OFS_IRQ_SEL 3'h4
// control register bit positions
`define HLCP_CTL_FLAG_BIT 2
`define HLCP_CTL_IRQ_EN_BIT 5
`define HLCP_CTL_MEM_EN_BIT 6
`define HLCP_CTL_RUN_BIT 7
// reset value and boot handshake codes
`define HLCP_SPAN_RST 8'h3f
`define HLCP_BOOT_CODE 8'h41
`define HLCP_BOOT_IDLE 8'hff
// boot code settles this long after reset release
`define HLCP_BOOT_NS 1000
`define HLCP_CLK_NS 4
`define HLCP_BOOT_CYC ((`HLCP_BOOT_NS + `HLCP_CLK_NS - 1) / `HLCP_CLK_NS)

`endif

//--- hlcp_pkg.sv
// hlcp_pkg.sv: types of the host load control port.
// assumes nothing beyond a SystemVerilog compiler.
package hlcp_pkg;

    // host i/o cycle toward the card registers
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic rd;
        logic wr;
    } hlcp_io_req_t;

    // control register layout
    typedef struct packed {
        logic run;
        logic mem_en;
        logic irq_en;
        logic [2:0] spare_hi;
        logic [1:0] spare_lo;
    } hlcp_ctl_t;

    typedef enum logic [1:0] {
        HLCP_IN_RESET,
        HLCP_BOOTING,
        HLCP_READY
    } hlcp_boot_t;

endpackage : hlcp_pkg

//--- hlcp_sync2.sv
// hlcp_sync2.sv: two flip-flop synchroniser for one level.
// assumes i_d is asynchronous to i_clk.
`timescale 1ns/1ns
module hlcp_sync2 (
    input wire logic i_clk, // sampling clock
    input wire logic i_d, // asynchronous level
    output logic o_q // synchronised level
);
    logic meta_r;
    logic sync_r;

    // first stage feeds only the second
    always_ff @(posedge i_clk) begin
        meta_r <= i_d;
        sync_r <= meta_r;
    end

    assign o_q = sync_r;
endmodule : hlcp_sync2

//--- hlcp_chk.sv
// hlcp_chk.sv: port assertions of the host load control port.
// assumes only the top ports; bound after the module.
`timescale 1ns/1ns
module hlcp_chk (
    input wire logic I_REF_CLK, // clock
    input wire logic I_SRST, // reset
    input wire hlcp_pkg::hlcp_io_req_t I_IO_REQ, // i/o cycle
    input wire logic [7:0] O_IO_RDATA, // read data
    input wire logic [19:12] I_MEM_ADDR_HI, // address byte
    input wire logic O_MEM_SELECT, // window hit
    input wire logic I_FW_STARTED, // firmware up
    input wire logic I_CARD_IRQ, // card request
    input wire logic O_CPU_RUN, // run
    input wire logic [15:0] O_HOST_IRQ, // lines
    input wire logic O_HOST_IRQ_OE // line enable
);
    default clocking @(posedge I_REF_CLK); endclocking
    default disable iff (I_SRST);
    // control register write strobe
    wire ctl_wr = I_IO_REQ.wr && I_IO_REQ.addr == 3'h1;
    sequence s_zero_wr;
        ctl_wr && I_IO_REQ.wdata == 8'h00;
    endsequence
    chk_zero_off: assert property (s_zero_wr |=> !O_CPU_RUN && !O_HOST_IRQ_OE)
        else $error("card active after zero");
    chk_window_off: assert property (s_zero_wr ##1 !ctl_wr [*3] |-> !O_MEM_SELECT)
        else $error("window hit while off");
    chk_run_bit: assert property (ctl_wr |=> O_CPU_RUN == $past(I_IO_REQ.wdata[7]))
        else $error("run bit wrong");
    chk_run_hold: assert property (!ctl_wr |=> $stable(O_CPU_RUN))
        else $error("run moved");
    chk_irq_off: assert property (ctl_wr && !I_IO_REQ.wdata[5] |=> !O_HOST_IRQ_OE)
        else $error("irq enable stuck");
    chk_irq_drive: assert property (O_HOST_IRQ_OE && I_CARD_IRQ |-> O_HOST_IRQ != 16'h0)
        else $error("irq not driven");
    chk_irq_lines: assert property (O_HOST_IRQ != 16'h0 |-> I_CARD_IRQ && $onehot(O_HOST_IRQ)
        && (O_HOST_IRQ & ~16'h9ea4) == 16'h0) else $error("bad irq line");
    chk_boot_code: assert property (I_IO_REQ.rd && I_IO_REQ.addr == 3'h0
        |=> O_IO_RDATA == 8'h41 || O_IO_RDATA == 8'hff) else $error("bad handshake");
endmodule : hlcp_chk
bind host_load_control_port hlcp_chk hlcp_chk_inst (.I_REF_CLK, .I_SRST, .I_IO_REQ, .O_IO_RDATA,
    .I_MEM_ADDR_HI, .O_MEM_SELECT, .I_FW_STARTED, .I_CARD_IRQ, .O_CPU_RUN, .O_HOST_IRQ, .O_HOST_IRQ_OE);

//--- hlcp_host.sv
// hlcp_host.sv: host model issuing one-cycle i/o strobes.
// assumes the card samples strobes on the rising edge.
`timescale 1ns/1ns
module hlcp_host (
    input wire logic i_clk, // bus clock
    output hlcp_pkg::hlcp_io_req_t o_req // i/o cycle
);
    initial o_req = '0;
    // strobe for one cycle, then release with changed lines
    task automatic io(input logic [2:0] a, input logic [7:0] d, input logic w);
        @(posedge i_clk);
        o_req <= '{addr: a, wdata: d, rd: !w, wr: w};
        @(posedge i_clk);
        o_req <= '{addr: ~a, wdata: ~d, rd: 1'b0, wr: 1'b0};
    endtask : io
endmodule : hlcp_host

//--- testbench.sv
// testbench.sv: boot, window, interrupt and start-up checks.
// assumes the host model and the bound checker.
`timescale 1ns/1ns
`include "hlcp_consts.svh"
module testbench;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [19:12] addr_hi = 8'h00;
    logic fw = 1'b0;
    logic card_irq = 1'b0;
    logic rd_d = 1'b0;
    logic sel, run, irq_oe;
    logic [7:0] rdata, base, a;
    logic [15:0] irq;
    logic [15:0] legal = 16'h9ea4;
    logic [7:0] exp_q[$];
    hlcp_pkg::hlcp_io_req_t req;
    int error_cnt = 0, n_checks = 0, cyc = 0, seed = 17356;
    always #2 clk = ~clk;
    hlcp_host hlcp_host_inst (.i_clk(clk), .o_req(req));
    host_load_control_port host_load_control_port_inst (.I_REF_CLK(clk), .I_SRST(srst), .I_IO_REQ(req),
        .O_IO_RDATA(rdata), .I_MEM_ADDR_HI(addr_hi), .O_MEM_SELECT(sel), .I_FW_STARTED(fw),
        .I_CARD_IRQ(card_irq), .O_CPU_RUN(run), .O_HOST_IRQ(irq), .O_HOST_IRQ_OE(irq_oe));
    task automatic print_verdict();
        if (error_cnt == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : print_verdict
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        n_checks++;
        if (seen !== want) begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check
    // reads note their expected byte for the monitor
    task automatic rd(input logic [2:0] ad, input logic [7:0] want);
        exp_q.push_back(want);
        hlcp_host_inst.io(ad, 8'h00, 1'b0);
    endtask : rd
    // monitor of read data, plus timeout
    always @(posedge clk) begin
        rd_d <= req.rd;
        cyc <= cyc + 1;
        if (rd_d) check(16'(rdata), 16'(exp_q.pop_front()));
        if (cyc == 3000) begin
            error_cnt++;
            print_verdict();
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        rd(3'h0, `HLCP_BOOT_IDLE);
        repeat (`HLCP_BOOT_CYC) @(posedge clk);
        rd(3'h0, 8'h41);
        rd(3'h3, 8'h3f);
        rd(3'h5, 8'h00);
        base = 8'($random(seed));
        hlcp_host_inst.io(3'h1, 8'h00, 1'b1);
        @(posedge clk) addr_hi <= base;
        @(negedge clk) check(16'(sel), 16'h0);
        hlcp_host_inst.io(3'h2, base, 1'b1);
        hlcp_host_inst.io(3'h3, 8'h0f, 1'b1);
        hlcp_host_inst.io(3'h1, 8'h40, 1'b1);
        rd(3'h2, base);
        for (int i = 0; i < 8; i++) begin
            a = 8'($random(seed));
            if (i[0]) a = base ^ (a & 8'h0f);
            if (i == 0) a = base;
            if (i[1:0] == 2'h2) hlcp_host_inst.io(3'h1, 8'h40, 1'b1);
            @(posedge clk) addr_hi <= a;
            @(negedge clk) check(16'(sel), 16'(((a ^ base) & 8'hf0) == 8'h00));
        end
        @(posedge clk) card_irq <= 1'b1;
        for (int c = 0; c < 16; c++) begin
            hlcp_host_inst.io(3'h4, 8'(c), 1'b1);
            hlcp_host_inst.io(3'h1, 8'h60, 1'b1);
            #1 check(irq, legal[c] ? 16'h1 << c : 16'h0);
            check(16'(irq_oe), 16'(legal[c]));
        end
        @(posedge clk) card_irq <= 1'b0;
        @(negedge clk) check(irq, 16'h0);
        hlcp_host_inst.io(3'h1, 8'he0, 1'b1);
        #1 check(16'(run), 16'h1);
        @(posedge clk) fw <= 1'b1;
        repeat (6) @(posedge clk);
        rd(3'h1, 8'he4);
        hlcp_host_inst.io(3'h1, 8'h00, 1'b1);
        #1 check({14'h0, run, sel}, 16'h0);
        rd(3'h1, 8'h00);
        @(posedge clk) srst <= 1'b1;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        rd(3'h0, `HLCP_BOOT_IDLE);
        rd(3'h3, `HLCP_SPAN_RST);
        repeat (2) @(posedge clk);
        print_verdict();
    end
endmodule : testbench
